// File: inc/ssic_pkg.sv
package ssic_pkg;
   // Default address width (word address, including the two burst bits).
   localparam int ADDR_W_DEF  = 8;
   // Default number of byte lanes.
   localparam int LANES_DEF   = 4;
   // Bits per data byte lane.
   localparam int BYTE_W      = 8;
   // Number of low-order address bits that form the burst counter.
   localparam int BURST_W     = 2;
   // Reset and load value of the burst step count.
   localparam logic [1:0] BURST_RST = 2'h0;
   // Reset value of the captured burst order: interleaved, as for a floating strap.
   localparam logic       STRAP_RST = 1'b1;
   // Access kinds held in the control pipeline.
   typedef enum logic [1:0] {
      SSIC_IDLE,
      SSIC_READ,
      SSIC_WRITE
   } ssic_op_t;
endpackage

// File: logic/ssic_top.sv
`timescale 1ns/10ps
// Operation
// (RULE1) Latch address including burst bits on edge.
// (RULE2) Lane selects active low, need write strobe.
// (RULE3) Each lane select gates byte and parity.
// (RULE4) Write strobe sampled only on qualified edges.
// (RULE5) Controller drives strobe low to write.
// (RULE6) Advance high on qualified edge increments counter.
// (RULE7) Advance low loads a fresh address.
// (RULE8) Controller loads address after deselect.
// (RULE9) Edges ignored while clock qualify high.
// (RULE10) All inputs captured on rising edge.
// (RULE11) Second select high, first and third low.
// (RULE12) Selected only when all three asserted.
// (RULE13) Qualify high freezes state, no deselect.
// (RULE14) Burst order strap: high interleaved, low linear.
// (RULE15) Outputs tristated on write, wake, deselect.
// (RULE16) Unselected lanes keep stored byte and parity.
module ssic_top #(
   parameter int ADDR_W = ssic_pkg::ADDR_W_DEF,
   parameter int LANES  = ssic_pkg::LANES_DEF
) (
   // Clock and reset.
   input  wire logic                               clk_i,
   input  wire logic                               resetn_i,
   // Control inputs from the memory controller.
   input  wire logic                               clock_qualify_n_i,
   input  wire logic                               write_strobe_n_i,
   input  wire logic                               advance_or_load_sel_i,
   input  wire logic                               chip_sel_first_n_i,
   input  wire logic                               chip_sel_second_i,
   input  wire logic                               chip_sel_third_n_i,
   input  wire logic                               burst_order_strap_i,
   // Address and byte-lane write selects.
   input  wire logic [ADDR_W-1:0]                  addr_i,
   input  wire logic [LANES-1:0]                   lane_write_sel_n_i,
   // Data and parity pins, split into in, out and enable.
   input  wire logic [LANES*ssic_pkg::BYTE_W-1:0]  data_lane_i,
   input  wire logic [LANES-1:0]                   parity_lane_i,
   output logic      [LANES*ssic_pkg::BYTE_W-1:0]  data_lane_o,
   output logic      [LANES-1:0]                   parity_lane_o,
   output logic                                    data_lane_oe_o,
   // Status of the captured access.
   output logic      [ADDR_W-1:0]                  cur_addr_o,
   output logic                                    selected_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Constants and storage.

   localparam int DW    = LANES * ssic_pkg::BYTE_W;
   localparam int DEPTH = 1 << ADDR_W;

   // Parameters that the logic cannot serve are refused.
   if (LANES < 1 || LANES > 4 || ADDR_W < 3 || ADDR_W > 16) begin : g_bad
      $error("ssic_top: unsupported ADDR_W or LANES.");
   end

   // Next burst offset in either order.
   function automatic logic [1:0] burst_next(input logic [1:0] start, input logic [1:0] cnt,
                                             input logic interleave);
      logic [1:0] step;
      step = cnt + 2'h1;
      burst_next = interleave ? (start ^ step) : (start + step);
   endfunction

   // Memory array of data bytes and parity bits, one word per location.
   logic [DW-1:0]      mem_data [DEPTH];
   logic [LANES-1:0]   mem_par  [DEPTH];

   ////////////////////////////////////////////////////////////////////////////
   // Control pipeline state.

   logic [ADDR_W-1:0]    base_r,  base_nxt;     // Loaded address.
   logic [1:0]           cnt_r,   cnt_nxt;      // Burst step count.
   ssic_pkg::ssic_op_t   op_r,    op_nxt;       // Access of the last cycle.
   logic [LANES-1:0]     lanes_r, lanes_nxt;    // Write lanes of the last cycle.
   logic                 sel_r,   sel_nxt;      // Selected at the last qualified load.
   logic                 wake_r,  wake_nxt;     // First cycle after deselect.
   logic                 strap_r, strap_nxt;    // Burst order captured after reset.
   logic                 strap_ok_r;            // Strap already captured.
   logic                 chip_sel;              // All three chip selects at their asserted levels.
   logic [ADDR_W-1:0]    eff_addr;              // Location addressed in the current cycle.
   logic [DW-1:0]        rd_data_r;             // Registered read data bytes.
   logic [LANES-1:0]     rd_par_r;              // Registered read parity bits.

   // Joint chip-select decode.
   assign chip_sel = !chip_sel_first_n_i && chip_sel_second_i && !chip_sel_third_n_i; // RULE11 RULE12

   // Current address: upper bits loaded, low bits from the burst order.
   assign eff_addr = {base_r[ADDR_W-1:2], (cnt_r == 2'h0) ? base_r[1:0]
                      : burst_next(base_r[1:0], cnt_r - 2'h1, strap_r)};

   // Next values for the control state.
   always_comb begin
      base_nxt  = base_r;
      cnt_nxt   = cnt_r;
      op_nxt    = op_r;
      lanes_nxt = lanes_r;
      sel_nxt   = sel_r;
      wake_nxt  = wake_r;
      strap_nxt = strap_ok_r ? strap_r : burst_order_strap_i; // RULE14
      // A high qualify leaves every field except the strap capture as it stands.
      if (!clock_qualify_n_i) begin // RULE9 RULE13 RULE10
         if (!advance_or_load_sel_i) begin
            // Load a fresh address and restart the burst.
            sel_nxt  = chip_sel;
            wake_nxt = chip_sel && !sel_r; // RULE15
            base_nxt = addr_i; // RULE1 RULE7
            cnt_nxt  = ssic_pkg::BURST_RST;
            if (!chip_sel) begin
               // Deselected: no access follows.
               op_nxt = ssic_pkg::SSIC_IDLE;
            end else if (!write_strobe_n_i) begin // RULE4 RULE2
               // Strobe low: the next cycle is a write data phase.
               op_nxt = ssic_pkg::SSIC_WRITE;
            end else begin
               // Strobe high: a read.
               op_nxt = ssic_pkg::SSIC_READ;
            end
            lanes_nxt = write_strobe_n_i ? '0 : ~lane_write_sel_n_i; // RULE2
         end else begin
            // Advance the burst and keep the access kind.
            cnt_nxt  = cnt_r + 2'h1; // RULE6
            wake_nxt = 1'b0;
            if (op_r == ssic_pkg::SSIC_WRITE) begin
               // A write burst takes fresh lane selects at each advance.
               lanes_nxt = ~lane_write_sel_n_i; // RULE2
            end
         end
      end
   end

   // Registers of the control state.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         base_r     <= '0;
         cnt_r      <= ssic_pkg::BURST_RST;
         op_r       <= ssic_pkg::SSIC_IDLE;
         lanes_r    <= '0;
         sel_r      <= 1'b0;
         wake_r     <= 1'b0;
         strap_r    <= ssic_pkg::STRAP_RST;
         strap_ok_r <= 1'b0;
      end else begin
         base_r     <= base_nxt;
         cnt_r      <= cnt_nxt;
         op_r       <= op_nxt;
         lanes_r    <= lanes_nxt;
         sel_r      <= sel_nxt;
         wake_r     <= wake_nxt;
         strap_r    <= strap_nxt;
         strap_ok_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data phase: writes land one cycle after the command, reads are registered.

   // Storage write with per-lane gating; no reset so the array stays plain.
   always_ff @(posedge clk_i) begin
      if (!clock_qualify_n_i && op_r == ssic_pkg::SSIC_WRITE) begin
         for (int l = 0; l < LANES; l++) begin
            if (lanes_r[l]) begin // RULE3 RULE16
               mem_data[eff_addr][l*ssic_pkg::BYTE_W +: ssic_pkg::BYTE_W] <=
                  data_lane_i[l*ssic_pkg::BYTE_W +: ssic_pkg::BYTE_W];
               mem_par[eff_addr][l] <= parity_lane_i[l];
            end
         end
      end
   end

   // Read data register.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rd_data_r <= '0;
         rd_par_r  <= '0;
      end else if (!clock_qualify_n_i) begin
         // Only qualified edges move the read pipeline.
         rd_data_r <= mem_data[eff_addr];
         rd_par_r  <= mem_par[eff_addr];
      end
   end

   // Outputs: driven only for a selected read past its wake cycle.
   assign data_lane_o    = rd_data_r;
   assign parity_lane_o  = rd_par_r;
   assign data_lane_oe_o = sel_r && !wake_r && op_r == ssic_pkg::SSIC_READ; // RULE15
   assign cur_addr_o     = eff_addr;
   assign selected_o     = sel_r;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.

   // A disqualified edge must leave the loaded address, count and selection alone.
   property p_freeze;
      @(posedge clk_i) disable iff (!resetn_i)
      clock_qualify_n_i |=> $stable(base_r) && $stable(cnt_r) && $stable(sel_r);
   endproperty
   a_freeze: assert property (p_freeze) else $error("State changed on unqualified edge."); // RULE13

   // A qualified load takes the pins' address and restarts the burst.
   property p_load;
      @(posedge clk_i) disable iff (!resetn_i)
      !clock_qualify_n_i && !advance_or_load_sel_i |=> base_r == $past(addr_i) && cnt_r == 2'h0;
   endproperty
   a_load: assert property (p_load) else $error("Fresh address not loaded."); // RULE7

   // A qualified advance steps the counter and keeps the loaded address.
   property p_adv;
      @(posedge clk_i) disable iff (!resetn_i)
      !clock_qualify_n_i && advance_or_load_sel_i |=> cnt_r == $past(cnt_r) + 2'h1 && $stable(base_r);
   endproperty
   a_adv: assert property (p_adv) else $error("Burst counter did not advance."); // RULE6

   // Selection follows the joint decode of the three selects at a load.
   property p_sel;
      @(posedge clk_i) disable iff (!resetn_i)
      !clock_qualify_n_i && !advance_or_load_sel_i |=> sel_r == $past(chip_sel);
   endproperty
   a_sel: assert property (p_sel) else $error("Selection not decided jointly."); // RULE12

   // A load with the strobe high never starts a write.
   property p_wr;
      @(posedge clk_i) disable iff (!resetn_i)
      !clock_qualify_n_i && !advance_or_load_sel_i && write_strobe_n_i
         |=> op_r != ssic_pkg::SSIC_WRITE && lanes_r == '0;
   endproperty
   a_wr: assert property (p_wr) else $error("Write started without strobe."); // RULE4

   // A selected load with the strobe low captures the lane selects.
   property p_lanes;
      @(posedge clk_i) disable iff (!resetn_i)
      !clock_qualify_n_i && !advance_or_load_sel_i && !write_strobe_n_i && chip_sel
         |=> op_r == ssic_pkg::SSIC_WRITE && lanes_r == ~$past(lane_write_sel_n_i);
   endproperty
   a_lanes: assert property (p_lanes) else $error("Lane selects not captured."); // RULE2

   // After a deselect, a wake from deselect or a write command, the pins float.
   property p_oe;
      @(posedge clk_i) disable iff (!resetn_i)
      !clock_qualify_n_i && !advance_or_load_sel_i && (!chip_sel || !sel_r || !write_strobe_n_i)
         |=> !data_lane_oe_o;
   endproperty
   a_oe: assert property (p_oe) else $error("Outputs driven while they must float."); // RULE15

   // Once captured, the burst order holds until the next reset.
   property p_strap;
      @(posedge clk_i) disable iff (!resetn_i)
      strap_ok_r |=> $stable(strap_r);
   endproperty
   a_strap: assert property (p_strap) else $error("Burst order changed in operation."); // RULE14

endmodule

// File: tb/ssic_ctrl_model.sv
`timescale 1ns/10ps
// Memory controller model: each command lands just after a falling edge.
module ssic_ctrl_model (
   // Clock.
   input  wire logic        clk_i,
   // Commands, address and write data.
   output logic             qual_n_o,
   output logic             we_n_o,
   output logic             adv_o,
   output logic [2:0]       cs_o,
   output logic [7:0]       addr_o,
   output logic [3:0]       lanes_n_o,
   output logic [31:0]      data_o,
   output logic [3:0]       par_o
);
   // Idle bus at time zero: deselected, no write.
   initial begin
      qual_n_o  = 1'b0;
      we_n_o    = 1'b1;
      adv_o     = 1'b0;
      cs_o      = 3'h5;
      addr_o    = 8'h0;
      lanes_n_o = 4'hf;
      data_o    = 32'h0;
      par_o     = 4'h0;
   end
   // One command cycle; outside a data phase the data lines toggle so stale data cannot pass.
   task automatic drive(input logic q, input logic w, input logic a, input logic [2:0] c, input logic [7:0] ad,
                        input logic [3:0] l, input logic dp, input logic [31:0] d, input logic [3:0] p);
      @(negedge clk_i);
      qual_n_o  <= q;
      we_n_o    <= w;
      adv_o     <= (cs_o == 3'h2) ? a : 1'b0;
      cs_o      <= c;
      addr_o    <= ad;
      lanes_n_o <= l;
      data_o    <= dp ? d : ~data_o;
      par_o     <= dp ? p : ~par_o;
   endtask
endmodule

// File: tb/tb_ssic_top.sv
`timescale 1ns/10ps
// Self-checking bench for the input control block.
module tb_ssic_top;
   localparam logic [2:0] SEL = 3'h2; // All three chip selects asserted.
   logic        clk_i    = 1'b0;
   logic        resetn_i = 1'b0;
   logic        strap    = 1'b1; // Burst order strap, interleaved until the mid-run reset.
   logic        q_n, we_n, adv, oe, sel;
   logic [2:0]  cs;
   logic [7:0]  addr, cur;
   logic [3:0]  ln_n, par, par_o;
   logic [31:0] dat, dat_o;
   int          n_fail   = 0;
   int          n_checks = 0;
   int          cyc      = 0;
   // Clock at 25 MHz.
   always #20 clk_i = ~clk_i;
   ssic_ctrl_model m (.clk_i(clk_i), .qual_n_o(q_n), .we_n_o(we_n), .adv_o(adv), .cs_o(cs), .addr_o(addr),
      .lanes_n_o(ln_n), .data_o(dat), .par_o(par));
   ssic_top dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .clock_qualify_n_i(q_n), .write_strobe_n_i(we_n),
      .advance_or_load_sel_i(adv), .chip_sel_first_n_i(cs[0]), .chip_sel_second_i(cs[1]),
      .chip_sel_third_n_i(cs[2]), .burst_order_strap_i(strap), .addr_i(addr), .lane_write_sel_n_i(ln_n),
      .data_lane_i(dat), .parity_lane_i(par), .data_lane_o(dat_o), .parity_lane_o(par_o),
      .data_lane_oe_o(oe), .cur_addr_o(cur), .selected_o(sel));
   // Prints the verdict and ends the run.
   task automatic final_report;
      if (n_fail == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Counts one comparison and reports a mismatch.
   task automatic chk(input logic ok, input string msg);
      n_checks++;
      if (!ok) begin
         n_fail++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   // Write command, then its data phase carried by a read of the same place.
   task automatic wr(input logic [7:0] a, input logic [3:0] l, input logic [31:0] d, input logic [3:0] p);
      m.drive(1'b0, 1'b0, 1'b0, SEL, a, l, 1'b0, 32'h0, 4'h0);
      m.drive(1'b0, 1'b1, 1'b0, SEL, a, 4'hf, 1'b1, d, p);
      chk(oe === 1'b0, "pins driven in write data phase");
   endtask
   // Read and compare after the two-cycle pipeline.
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [3:0] p);
      m.drive(1'b0, 1'b1, 1'b0, SEL, a, 4'hf, 1'b0, 32'h0, 4'h0);
      m.drive(1'b0, 1'b1, 1'b0, SEL, a, 4'hf, 1'b0, 32'h0, 4'h0);
      @(negedge clk_i);
      chk(dat_o === d && par_o === p && oe === 1'b1, "read data");
   endtask
   // Full, partial and strobe-less writes, and two neighbouring burst addresses.
   task automatic t_lanes;
      wr(8'h10, 4'h0, 32'h11223344, 4'ha);
      rd(8'h10, 32'h11223344, 4'ha);
      wr(8'h10, 4'ha, 32'haabbccdd, 4'h5);
      rd(8'h10, 32'h11bb33dd, 4'hf);
      m.drive(1'b0, 1'b1, 1'b0, SEL, 8'h10, 4'h0, 1'b0, 32'h0, 4'h0);
      m.drive(1'b0, 1'b1, 1'b0, SEL, 8'h10, 4'hf, 1'b1, 32'h0, 4'h0);
      rd(8'h10, 32'h11bb33dd, 4'hf);
      wr(8'h11, 4'h0, 32'h55667788, 4'h3);
      rd(8'h10, 32'h11bb33dd, 4'hf);
      rd(8'h11, 32'h55667788, 4'h3);
   endtask
   // A deselect with the write strobe low under a held clock qualifier must change nothing.
   task automatic t_qual;
      m.drive(1'b1, 1'b0, 1'b0, 3'h5, 8'h10, 4'h0, 1'b0, 32'h0, 4'h0);
      m.drive(1'b1, 1'b1, 1'b0, 3'h5, 8'h10, 4'hf, 1'b1, 32'h0, 4'h0);
      chk(cur === 8'h11 && sel === 1'b1, "state moved while frozen");
      rd(8'h10, 32'h11bb33dd, 4'hf);
   endtask
   // Load at an odd start, advance in interleaved order, then an advance on a disqualified edge.
   task automatic t_burst;
      m.drive(1'b0, 1'b1, 1'b0, SEL, 8'h21, 4'hf, 1'b0, 32'h0, 4'h0);
      m.drive(1'b0, 1'b1, 1'b1, SEL, 8'h21, 4'hf, 1'b0, 32'h0, 4'h0);
      chk(cur === 8'h21, "address load");
      m.drive(1'b1, 1'b1, 1'b1, SEL, 8'h24, 4'hf, 1'b0, 32'h0, 4'h0);
      chk(cur === 8'h20, "interleaved burst advance");
      m.drive(1'b0, 1'b1, 1'b0, SEL, 8'h24, 4'hf, 1'b0, 32'h0, 4'h0);
      chk(cur === 8'h20, "advance on frozen edge");
   endtask
   // Each chip select dropped alone, then all asserted.
   task automatic t_sel;
      logic [2:0] pat [4] = '{3'h3, 3'h0, 3'h6, SEL};
      for (int i = 0; i < 4; i++) begin
         m.drive(1'b0, 1'b1, 1'b0, pat[i], 8'h10, 4'hf, 1'b0, 32'h0, 4'h0);
         m.drive(1'b0, 1'b1, 1'b0, pat[i], 8'h10, 4'hf, 1'b0, 32'h0, 4'h0);
         chk(sel === (i == 3), "selection");
         chk(oe === 1'b0, "pins driven while deselected or waking");
      end
   endtask
   // Mid-run reset with the strap low, then a linear burst from an odd start.
   task automatic t_strap;
      @(negedge clk_i);
      resetn_i = 1'b0;
      strap    = 1'b0;
      @(negedge clk_i);
      chk(oe === 1'b0 && sel === 1'b0 && cur === 8'h00, "mid-run reset state");
      resetn_i = 1'b1;
      m.drive(1'b0, 1'b1, 1'b0, SEL, 8'h21, 4'hf, 1'b0, 32'h0, 4'h0);
      m.drive(1'b0, 1'b1, 1'b1, SEL, 8'h21, 4'hf, 1'b0, 32'h0, 4'h0);
      chk(cur === 8'h21, "load after reset");
      m.drive(1'b0, 1'b1, 1'b1, SEL, 8'h21, 4'hf, 1'b0, 32'h0, 4'h0);
      chk(cur === 8'h22, "linear burst advance");
      m.drive(1'b0, 1'b1, 1'b0, SEL, 8'h21, 4'hf, 1'b0, 32'h0, 4'h0);
      chk(cur === 8'h23, "second linear advance");
   endtask
   // Reset for 20 cycles, then the scenarios.
   initial begin
      repeat (20) @(negedge clk_i);
      chk(oe === 1'b0 && sel === 1'b0, "reset state");
      resetn_i = 1'b1;
      t_lanes;
      t_qual;
      t_burst;
      t_sel;
      t_strap;
      final_report;
   end
   // Hang guard.
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 1000) begin
         n_fail++;
         final_report;
      end
   end
endmodule
